// ### hdl/aml_atomic_unit.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - increment, decrement, pre-decrement carry no sources
// - compare-write carries first and second source
// - all other operations carry first source only
// - sources follow address payload directly
// - two-slot 64-bit sources at dwords 1:0, 5:4
// - signed min/max signed, others unsigned
// - two-slot 32-bit sources share one register
// - 128-bit compare-write: two slots per register
// - eight-slot 64-bit compare-write: four source registers
// - two-slot 64-bit compare-write: two source registers
// - writeback only when return enable set
// - only mask-enabled destination channels are written
// - eight-slot 64-bit results in two registers
// - eight-slot 32-bit result n in dword n
// - two-slot 64-bit results at dwords 1:0, 5:4
// - 128-bit results two per register
// - read-modify-write is indivisible
// - non-canonical address faults or goes out of bounds
// - no header, offsets absolute from zero
// - descriptor bit 13 return, bit 12 size
// - descriptor bits 11:8 select the operation
// - compare-write stores second source on match
module aml_atomic_unit #(
  parameter int MEM_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic msg_start_in,
  input wire logic [aml_pkg::DESC_W-1:0] msg_desc_in,
  input wire logic [7:0] msg_exec_mask_in,
  input wire logic msg_two_slot_in,
  output logic msg_ready_out,
  input wire logic beat_valid_in,
  input wire logic [aml_pkg::REG_W-1:0] beat_data_in,
  output logic beat_ready_out,
  output aml_pkg::aml_wb_t wb_out,
  output logic done_out,
  output logic fault_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);
  import aml_pkg::*;

  localparam int IDX_W = $clog2(MEM_DEPTH);

  generate
    if (MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("MEM_DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  aml_state_t state_reg;
  aml_desc_t desc_reg;
  logic [7:0] mask_reg;
  logic two_reg;
  logic [3:0] beat_cnt_reg;
  logic [2:0] slot_reg;
  logic [1:0] wb_cnt_reg;
  logic [REG_W-1:0] buf_reg [MAX_BEATS];
  logic [REG_W-1:0] wbbuf_reg [4];
  logic [63:0] mem_reg [MEM_DEPTH];
  logic nonfault_reg;
  logic fault_sticky_reg;
  logic oob_sticky_reg;
  logic [31:0] count_reg;
  aml_wb_t wb_reg;
  logic done_reg;
  logic fault_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // message shape
  // ----------------------------------------------------------------
  logic is_wide, is_cmp, no_src, exec_last, wb_last;
  logic [1:0] wsel, nsrc;
  logic [2:0] per_src;
  logic [3:0] addr_beats, src_beats, total_beats;

  always_comb begin
    is_wide = desc_reg.op == compare_write_wide_op;
    is_cmp = is_wide || desc_reg.op == compare_write_op;
    no_src = desc_reg.op == increment_op || desc_reg.op == decrement_op || desc_reg.op == pre_decrement_op;
    if (is_wide && desc_reg.size64) begin
      wsel = SZ_128;
    end else if (is_wide || desc_reg.size64) begin
      wsel = SZ_64;
    end else begin
      wsel = SZ_32;
    end
    if (no_src) begin
      nsrc = 2'h0;
    end else if (is_cmp) begin
      nsrc = 2'h2;
    end else begin
      nsrc = 2'h1;
    end
    per_src = two_reg ? 3'h1 : 3'(1 << wsel);
    addr_beats = two_reg ? 4'h1 : 4'h2;
    if (two_reg && wsel == SZ_32) begin
      src_beats = {3'h0, nsrc != 2'h0};
    end else begin
      src_beats = 4'(nsrc * per_src);
    end
    total_beats = addr_beats + src_beats;
    exec_last = slot_reg == (two_reg ? 3'h1 : 3'h7);
    wb_last = {1'b0, wb_cnt_reg} == per_src - 3'h1;
  end

  // ----------------------------------------------------------------
  // operand extraction for the current slot
  // ----------------------------------------------------------------
  logic slot_en;
  logic [2:0] sreg, kmask;
  logic [8:0] pos;
  logic [3:0] s0_idx, s1_idx;
  logic [REG_W-1:0] addr_sh, sh0, sh1;
  logic [63:0] slot_addr;

  always_comb begin
    slot_en = two_reg ? |mask_reg[{slot_reg[0], 2'h0} +: 4] : mask_reg[slot_reg];
    addr_sh = two_reg ? buf_reg[0] >> {slot_reg[0], 7'h00} : buf_reg[{3'h0, slot_reg[2]}] >> {slot_reg[1:0], 6'h00};
    slot_addr = addr_sh[63:0];
    kmask = 3'(7 >> wsel);
    sreg = two_reg ? 3'h0 : slot_reg >> (3 - wsel);
    // the two-slot mode of the message sets where sources start
    pos = two_reg ? {1'b0, slot_reg[0], 7'h00} : 9'(slot_reg & kmask) << (5 + wsel);
    s0_idx = addr_beats + {1'b0, sreg};
    if (two_reg) begin
      s1_idx = wsel == SZ_32 ? addr_beats : addr_beats + 4'h1;
    end else begin
      s1_idx = addr_beats + {1'b0, per_src} + {1'b0, sreg};
    end
    sh0 = buf_reg[s0_idx] >> pos;
    sh1 = (two_reg && wsel == SZ_32) ? buf_reg[s1_idx] >> (pos + 9'h020) : buf_reg[s1_idx] >> pos;
  end

  // ----------------------------------------------------------------
  // read-modify-write of one slot
  // ----------------------------------------------------------------
  logic canon_ok, in_range, do_write, is_signed;
  logic [IDX_W-1:0] qlo, qhi;
  logic [63:0] old64, a, b, c, new64, ret64, wlo;
  logic [127:0] old128, new128, ret128;

  always_comb begin
    canon_ok = slot_addr[CANON_TOP:CANON_LOW] == {16{slot_addr[CANON_SIGN]}};
    in_range = slot_addr[63:3+IDX_W] == '0;
    qlo = wsel == SZ_128 ? {slot_addr[3+IDX_W-1:4], 1'b0} : slot_addr[3 +: IDX_W];
    qhi = qlo | IDX_W'(1);
    old64 = mem_reg[qlo];
    old128 = {mem_reg[qhi], old64};
    is_signed = desc_reg.op == signed_max_op || desc_reg.op == signed_min_op;
    if (wsel == SZ_32) begin
      a = slot_addr[2] ? {{32{is_signed & old64[63]}}, old64[63:32]} : {{32{is_signed & old64[31]}}, old64[31:0]};
      b = {{32{is_signed & sh0[31]}}, sh0[31:0]};
      c = {32'h0, sh1[31:0]};
    end else begin
      a = old64;
      b = sh0[63:0];
      c = sh1[63:0];
    end
    case (desc_reg.op)
      and_op: new64 = a & b;
      or_op: new64 = a | b;
      xor_op: new64 = a ^ b;
      move_op: new64 = b;
      increment_op: new64 = a + 64'h1;
      decrement_op: new64 = a - 64'h1;
      pre_decrement_op: new64 = a - 64'h1;
      add_op: new64 = a + b;
      sub_op: new64 = a - b;
      rev_sub_op: new64 = b - a;
      signed_max_op: new64 = $signed(a) > $signed(b) ? a : b;
      signed_min_op: new64 = $signed(a) < $signed(b) ? a : b;
      unsigned_max_op: new64 = a > b ? a : b;
      unsigned_min_op: new64 = a < b ? a : b;
      compare_write_op: new64 = a == b ? c : a;
      compare_write_wide_op: new64 = a == b ? c : a;
      default: new64 = a;
    endcase
    new128 = sh0[127:0] == old128 ? sh1[127:0] : old128;
    ret64 = desc_reg.op == pre_decrement_op ? new64 : a;
    if (!canon_ok || !in_range) begin
      ret128 = 128'h0;
    end else if (wsel == SZ_128) begin
      ret128 = old128;
    end else if (wsel == SZ_32) begin
      ret128 = {96'h0, ret64[31:0]};
    end else begin
      ret128 = {64'h0, ret64};
    end
    if (wsel == SZ_128) begin
      wlo = new128[63:0];
    end else if (wsel == SZ_32) begin
      wlo = slot_addr[2] ? {new64[31:0], old64[31:0]} : {old64[63:32], new64[31:0]};
    end else begin
      wlo = new64;
    end
    do_write = state_reg == ST_EXEC && slot_en && canon_ok && in_range;
  end

  // memory is read and written in the same cycle, so no other slot or
  // message can interleave between the fetch and the store
  always_ff @(posedge clk_in) begin
    if (do_write) begin
      mem_reg[qlo] <= wlo;
      if (wsel == SZ_128) begin
        mem_reg[qhi] <= new128[127:64];
      end
    end
  end

  // ----------------------------------------------------------------
  // control sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ST_IDLE;
      desc_reg <= '0;
      mask_reg <= 8'h00;
      two_reg <= 1'b0;
      beat_cnt_reg <= 4'h0;
      slot_reg <= 3'h0;
      wb_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (msg_start_in) begin
            desc_reg <= {msg_desc_in[DESC_RET_BIT], msg_desc_in[DESC_SIZE_BIT], msg_desc_in[DESC_OP_LSB +: 4]};
            mask_reg <= msg_exec_mask_in;
            two_reg <= msg_two_slot_in;
            beat_cnt_reg <= 4'h0;
            slot_reg <= 3'h0;
            wb_cnt_reg <= 2'h0;
            state_reg <= ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          if (beat_valid_in) begin
            beat_cnt_reg <= beat_cnt_reg + 4'h1;
            if (beat_cnt_reg == total_beats - 4'h1) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          slot_reg <= slot_reg + 3'h1;
          if (exec_last) begin
            state_reg <= desc_reg.ret_en ? ST_RETURN : ST_IDLE;
          end
        end
        ST_RETURN: begin
          wb_cnt_reg <= wb_cnt_reg + 2'h1;
          if (wb_last) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (state_reg == ST_COLLECT && beat_valid_in) begin
      buf_reg[beat_cnt_reg] <= beat_data_in;
    end
  end

  // ----------------------------------------------------------------
  // writeback assembly
  // ----------------------------------------------------------------
  logic [1:0] wreg;
  logic [7:0] dw_en;
  logic [3:0] dslot;

  always_comb begin
    wreg = 2'(sreg);
    dw_en = 8'h00;
    dslot = 4'h0;
    for (int d = 0; d < 8; d++) begin
      if (two_reg) begin
        dslot = 4'(d >> 2);
        dw_en[d] = |mask_reg[dslot[0]*4 +: 4] && (d % 4) < (1 << wsel);
      end else begin
        dslot = 4'((wb_cnt_reg * 8 + d) >> wsel);
        dw_en[d] = dslot < 4'h8 && mask_reg[dslot[2:0]];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int r = 0; r < 4; r++) begin
        wbbuf_reg[r] <= '0;
      end
    end else if (state_reg == ST_IDLE && msg_start_in) begin
      for (int r = 0; r < 4; r++) begin
        wbbuf_reg[r] <= '0;
      end
    end else if (state_reg == ST_EXEC && slot_en) begin
      wbbuf_reg[wreg] <= wbbuf_reg[wreg] | ({128'h0, ret128} << pos);
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      wb_reg.valid <= state_reg == ST_RETURN;
      wb_reg.last <= state_reg == ST_RETURN && wb_last;
      wb_reg.dw_en <= state_reg == ST_RETURN ? dw_en : 8'h00;
      wb_reg.data <= state_reg == ST_RETURN ? wbbuf_reg[wb_cnt_reg] : '0;
      done_reg <= (state_reg == ST_EXEC && exec_last && !desc_reg.ret_en) || (state_reg == ST_RETURN && wb_last);
    end
  end

  // ----------------------------------------------------------------
  // faults and software registers
  // ----------------------------------------------------------------
  logic canon_bad;
  assign canon_bad = state_reg == ST_EXEC && slot_en && !canon_ok;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fault_reg <= 1'b0;
      fault_sticky_reg <= 1'b0;
      oob_sticky_reg <= 1'b0;
    end else begin
      fault_reg <= canon_bad && !nonfault_reg;
      // a new event beats a software clear in the same cycle
      if (canon_bad && !nonfault_reg) begin
        fault_sticky_reg <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == STATUS_OFS && reg_wdata_in[STATUS_FAULT_BIT]) begin
        fault_sticky_reg <= 1'b0;
      end
      // in faulting mode a non-canonical slot is a fault only, never also out of bounds
      if (state_reg == ST_EXEC && slot_en && ((canon_ok && !in_range) || (!canon_ok && nonfault_reg))) begin
        oob_sticky_reg <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == STATUS_OFS && reg_wdata_in[STATUS_OOB_BIT]) begin
        oob_sticky_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nonfault_reg <= CTRL_NONFAULT_RST;
      count_reg <= 32'h0;
      rdata_reg <= 32'h0;
    end else begin
      if (reg_wr_in && reg_addr_in == CTRL_OFS) begin
        nonfault_reg <= reg_wdata_in[CTRL_NONFAULT_BIT];
      end
      if (done_reg) begin
        count_reg <= count_reg + 32'h1;
      end
      if (reg_rd_in) begin
        case (reg_addr_in)
          CTRL_OFS: rdata_reg <= {31'h0, nonfault_reg};
          STATUS_OFS: rdata_reg <= {29'h0, oob_sticky_reg, fault_sticky_reg, state_reg != ST_IDLE};
          COUNT_OFS: rdata_reg <= count_reg;
          default: rdata_reg <= 32'h0;
        endcase
      end else begin
        rdata_reg <= 32'h0;
      end
    end
  end

  assign msg_ready_out = state_reg == ST_IDLE;
  assign beat_ready_out = state_reg == ST_COLLECT;
  assign wb_out = wb_reg;
  assign done_out = done_reg;
  assign fault_out = fault_reg;
  assign reg_rdata_out = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence seq_exec_end_ret;
    state_reg == ST_EXEC && exec_last && desc_reg.ret_en;
  endsequence
  sequence seq_wb_two;
    (wb_reg.valid && !wb_reg.last) ##1 (wb_reg.valid && wb_reg.last);
  endsequence
  sequence seq_wb_four;
    (wb_reg.valid && !wb_reg.last) [*3] ##1 (wb_reg.valid && wb_reg.last);
  endsequence

  chk_no_src_beats: assert property (state_reg == ST_COLLECT && no_src |-> total_beats == addr_beats)
    else $error("no-source operation expects source beats");
  chk_cmp_two_srcs: assert property (state_reg == ST_COLLECT && is_cmp && !two_reg |-> src_beats == 4'(2 * per_src))
    else $error("compare-write source count wrong");
  chk_one_src_only: assert property (state_reg == ST_COLLECT && !is_cmp && !no_src |-> src_beats == {1'b0, per_src})
    else $error("single-source operation count wrong");
  chk_wb_gate_ret: assert property (wb_reg.valid |-> desc_reg.ret_en)
    else $error("writeback without return enable");
  chk_wb_qword_eight: assert property (seq_exec_end_ret and (wsel == SZ_64 && !two_reg) |-> ##2 seq_wb_two)
    else $error("eight-slot 64-bit writeback not two registers");
  chk_wb_dword_lanes: assert property (wb_reg.valid && !two_reg && wsel == SZ_32 |-> wb_reg.dw_en == mask_reg)
    else $error("32-bit lane enables differ from mask");
  chk_wb_two_reserved: assert property (wb_reg.valid && two_reg && wsel == SZ_64 |-> wb_reg.dw_en[7:6] == 2'h0 && wb_reg.dw_en[3:2] == 2'h0)
    else $error("reserved dwords enabled in two-slot writeback");
  chk_wb_wide_four: assert property (seq_exec_end_ret and (wsel == SZ_128 && !two_reg) |-> ##2 seq_wb_four)
    else $error("128-bit writeback not four registers");
  chk_canon_fault: assert property (canon_bad && !nonfault_reg |=> fault_out && fault_sticky_reg)
    else $error("non-canonical address raised no fault");
  chk_masked_no_store: assert property (state_reg == ST_EXEC && !slot_en |-> !do_write)
    else $error("masked slot updated memory");

endmodule

// ### hdl/aml_pkg.sv
package aml_pkg;

  // ----------------------------------------------------------------
  // payload geometry
  // ----------------------------------------------------------------
  localparam int REG_W = 256;
  localparam int MAX_BEATS = 10;
  localparam int DESC_W = 14;
  localparam int DESC_RET_BIT = 13;
  localparam int DESC_SIZE_BIT = 12;
  localparam int DESC_OP_LSB = 8;

  // ----------------------------------------------------------------
  // canonical address check
  // ----------------------------------------------------------------
  localparam int CANON_TOP = 63;
  localparam int CANON_LOW = 48;
  localparam int CANON_SIGN = 47;

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [3:0] compare_write_wide_op = 4'h0;
  localparam logic [3:0] and_op = 4'h1;
  localparam logic [3:0] or_op = 4'h2;
  localparam logic [3:0] xor_op = 4'h3;
  localparam logic [3:0] move_op = 4'h4;
  localparam logic [3:0] increment_op = 4'h5;
  localparam logic [3:0] decrement_op = 4'h6;
  localparam logic [3:0] add_op = 4'h7;
  localparam logic [3:0] sub_op = 4'h8;
  localparam logic [3:0] rev_sub_op = 4'h9;
  localparam logic [3:0] signed_max_op = 4'hA;
  localparam logic [3:0] signed_min_op = 4'hB;
  localparam logic [3:0] unsigned_max_op = 4'hC;
  localparam logic [3:0] unsigned_min_op = 4'hD;
  localparam logic [3:0] compare_write_op = 4'hE;
  localparam logic [3:0] pre_decrement_op = 4'hF;

  // operand width select: log2 of dwords per slot
  localparam logic [1:0] SZ_32 = 2'h0;
  localparam logic [1:0] SZ_64 = 2'h1;
  localparam logic [1:0] SZ_128 = 2'h2;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam int CTRL_NONFAULT_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_FAULT_BIT = 1;
  localparam int STATUS_OOB_BIT = 2;
  localparam logic CTRL_NONFAULT_RST = 1'b0;

  typedef struct packed {
    logic ret_en;
    logic size64;
    logic [3:0] op;
  } aml_desc_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] dw_en;
    logic [REG_W-1:0] data;
  } aml_wb_t;

  typedef enum logic [1:0] {ST_IDLE, ST_COLLECT, ST_EXEC, ST_RETURN} aml_state_t;

endpackage

// ### tb/aml_sender.sv
`timescale 1ns/1ns
module aml_sender (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ready_in,
  input wire logic [aml_pkg::MAX_BEATS*aml_pkg::REG_W-1:0] beats_in,
  input wire logic [3:0] count_in,
  output logic valid_out,
  output logic [aml_pkg::REG_W-1:0] data_out
);
  import aml_pkg::*;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  assign idx_next = idx_reg + {3'h0, valid_out};
  // ----------------------------------------------------------------
  // beat sequencing
  // ----------------------------------------------------------------
  // count_in holds the address registers plus only the needed sources, no header
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      idx_reg <= 4'h0;
      valid_out <= 1'b0;
      data_out <= '0;
    end else if (!ready_in) begin
      // an idle line shows the inverse of its last value, never a stale copy
      idx_reg <= 4'h0;
      valid_out <= 1'b0;
      data_out <= ~data_out;
    end else begin
      idx_reg <= idx_next;
      valid_out <= (idx_next < count_in);
      data_out <= (idx_next < count_in) ? beats_in[idx_next*REG_W +: REG_W] : ~data_out;
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import aml_pkg::*;
  logic clk_in = 1'b0, arst_n_in = 1'b0, msg_start_in = 1'b0, msg_two_slot_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, msg_ready_out, beat_valid_in, beat_ready_out, done_out, fault_out;
  logic [DESC_W-1:0] msg_desc_in = '0;
  logic [7:0] msg_exec_mask_in = '0, reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic [REG_W-1:0] beat_data_in, wbd [4], ed [4];
  logic [7:0] wbe [4], ee [4];
  aml_wb_t wb_out;
  logic [MAX_BEATS*REG_W-1:0] beats = '0;
  logic [3:0] nbeat = '0;
  logic [63:0] m [16], s0 [8], s1 [8];
  int num_errors = 0, checked = 0, wb_cnt = 0, flt = 0, msgs = 0;

  aml_atomic_unit #(.MEM_DEPTH(16)) i_aml_atomic_unit (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .msg_start_in(msg_start_in), .msg_desc_in(msg_desc_in), .msg_exec_mask_in(msg_exec_mask_in),
    .msg_two_slot_in(msg_two_slot_in), .msg_ready_out(msg_ready_out), .beat_valid_in(beat_valid_in),
    .beat_data_in(beat_data_in), .beat_ready_out(beat_ready_out), .wb_out(wb_out), .done_out(done_out),
    .fault_out(fault_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));
  aml_sender i_aml_sender (.clk_in(clk_in), .arst_n_in(arst_n_in), .ready_in(beat_ready_out),
    .beats_in(beats), .count_in(nbeat), .valid_out(beat_valid_in), .data_out(beat_data_in));

  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (wb_out.valid === 1'b1 && wb_cnt < 4) begin
      wbd[wb_cnt] = wb_out.data;
      wbe[wb_cnt] = wb_out.dw_en;
      wb_cnt++;
    end
    if (fault_out === 1'b1) flt++;
  end

  task automatic chk(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic put(input int b, input int p, input logic [63:0] v);
    beats[b*REG_W+p +: 64] = v;
  endtask
  task automatic clr();
    beats = '0;
    ed = '{default: '0};
    ee = '{default: '0};
  endtask
  task automatic run(input logic [DESC_W-1:0] d, input logic [7:0] mk, input logic two, input logic [3:0] n);
    wb_cnt = 0;
    flt = 0;
    @(posedge clk_in);
    nbeat <= n;
    msg_desc_in <= d;
    msg_exec_mask_in <= mk;
    msg_two_slot_in <= two;
    msg_start_in <= 1'b1;
    @(posedge clk_in);
    msg_start_in <= 1'b0;
    @(posedge clk_in);
    chk(msg_ready_out, 1'b0);
    for (int i = 0; i < 60; i++) begin
      if (done_out === 1'b1) break;
      @(posedge clk_in);
    end
    chk(done_out, 1'b1);
    chk(msg_ready_out, 1'b1);
    msgs++;
    @(posedge clk_in);
  endtask
  task automatic cmp_wb(input int n);
    for (int i = 0; i < n; i++) begin
      chk(wbd[i], ed[i]);
      chk(wbe[i], ee[i]);
    end
  endtask
  // eight-slot 64-bit message; slot s works on qword s, so the memory mirror stays exact
  task automatic eight64(input logic [3:0] op, input logic r, input logic [7:0] mk, input int ns);
    clr();
    for (int s = 0; s < 8; s++) begin
      put(s/4, (s%4)*64, 64'(8*s));
      put(2+s/4, (s%4)*64, s0[s]);
      if (ns == 2) put(4+s/4, (s%4)*64, s1[s]);
      if (mk[s]) begin
        ed[s/4][(s%4)*64 +: 64] = m[s];
        ee[s/4][(s%4)*2 +: 2] = 2'h3;
        case (op)
          move_op: m[s] = s0[s];
          add_op: m[s] = m[s] + s0[s];
          signed_max_op: if ($signed(s0[s]) > $signed(m[s])) m[s] = s0[s];
          default: if (s0[s] == m[s]) m[s] = s1[s];
        endcase
      end
    end
    run({r, op != 4'h0, op, 8'h00}, mk, 1'b0, 4'(2 + 2*ns));
    chk(wb_cnt, r ? 2 : 0);
    if (r) cmp_wb(2);
  endtask
  // eight-slot 128-bit compare-write on qword pairs 0-3; slots 4-7 stay masked off
  task automatic wide128();
    clr();
    for (int s = 0; s < 4; s++) begin
      put(0, s*64, 64'(16*s));
      put(2+s/2, (s%2)*128, m[2*s]);
      put(2+s/2, (s%2)*128+64, s[0] ? ~m[2*s+1] : m[2*s+1]);
      put(6+s/2, (s%2)*128, 64'hA0 + s);
      put(6+s/2, (s%2)*128+64, 64'hB0 + s);
      ed[s/2][(s%2)*128 +: 128] = {m[2*s+1], m[2*s]};
      ee[s/2][(s%2)*4 +: 4] = 4'hF;
      if (!s[0]) begin
        m[2*s] = 64'hA0 + s;
        m[2*s+1] = 64'hB0 + s;
      end
    end
    run({1'b1, 1'b1, compare_write_wide_op, 8'h00}, 8'h0F, 1'b0, 4'hA);
    chk(wb_cnt, 4);
    cmp_wb(4);
  endtask
  task automatic prep(input logic [63:0] k);
    for (int s = 0; s < 8; s++) begin
      s0[s] = s[0] ? ~m[s] : m[s];
      s1[s] = k + s;
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(CTRL_OFS, 32'h0);
    rd(STATUS_OFS, 32'h0);
    rd(COUNT_OFS, 32'h0);
    rd(8'h0C, 32'h0);
    for (int s = 0; s < 8; s++) s0[s] = 64'h0123_4567_89AB_CD00 + s;
    eight64(move_op, 1'b0, 8'hFF, 1);
    s0 = '{default: 64'h10};
    eight64(add_op, 1'b1, 8'hA5, 1);
    s0 = '{default: '1};
    eight64(signed_max_op, 1'b1, 8'h02, 1);
    prep(64'hC0DE_0000);
    eight64(compare_write_wide_op, 1'b1, 8'hFF, 2);
    prep(64'hBEEF_0000);
    eight64(compare_write_op, 1'b1, 8'h3C, 2);
    wide128();
    // two-slot 64-bit add on qwords 0 and 1
    clr();
    put(0, 128, 64'h8);
    put(1, 0, 64'h5);
    put(1, 128, 64'h7);
    ed[0][63:0] = m[0];
    ed[0][191:128] = m[1];
    ee[0] = 8'h33;
    run({1'b1, 1'b1, add_op, 8'h00}, 8'h11, 1'b1, 4'h2);
    chk(wb_cnt, 1);
    cmp_wb(1);
    // two-slot 32-bit compare-write, slot 1 masked off
    clr();
    put(0, 0, 64'd16);
    put(0, 128, 64'd24);
    put(1, 0, {32'h0000_FEED, m[2][31:0]});
    put(1, 128, 64'h1_0000_0002);
    ed[0][31:0] = m[2][31:0];
    ee[0] = 8'h01;
    run({1'b1, 1'b0, compare_write_op, 8'h00}, 8'h01, 1'b1, 4'h2);
    chk(wb_cnt, 1);
    cmp_wb(1);
    // eight-slot 32-bit decrement, no sources; slot 0 sees the stored word
    clr();
    put(0, 0, 64'd16);
    put(1, 192, 64'd28);
    ed[0][31:0] = 32'h0000_FEED;
    ed[0][255:224] = m[3][63:32];
    ee[0] = 8'h81;
    run({1'b1, 1'b0, decrement_op, 8'h00}, 8'h81, 1'b0, 4'h2);
    chk(wb_cnt, 1);
    cmp_wb(1);
    // non-canonical address, faulting then non-faulting mode
    clr();
    put(0, 0, 64'h0001_0000_0000_0000);
    put(1, 0, 64'h1);
    run({1'b1, 1'b1, add_op, 8'h00}, 8'h01, 1'b1, 4'h2);
    chk(flt, 1);
    chk(wbd[0], '0);
    rd(STATUS_OFS, 32'h2);
    wr(STATUS_OFS, 32'h2);
    rd(STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h1);
    run({1'b1, 1'b1, add_op, 8'h00}, 8'h01, 1'b1, 4'h2);
    chk(flt, 0);
    rd(STATUS_OFS, 32'h4);
    rd(COUNT_OFS, 32'(msgs));
    conclude();
  end
endmodule
